// file: rtl/ltq_trigger.sv
// Logic trigger qualifier top: pattern and state classes, holdoff,
// auto or normal acquisition, register port and interrupt.
// Assumes thresholded asynchronous inputs and a strobe-style register master.
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module ltq_trigger (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RSTN,
  input  wire logic        I_INPUT_ONE,
  input  wire logic        I_INPUT_TWO,
  input  wire logic        I_INPUT_THREE,
  input  wire logic        I_INPUT_FOUR_CLOCK,
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic [31:0]      O_RDATA,
  output logic             O_TRIGGER,
  output logic             O_ACQ_START,
  output logic             O_ARMED,
  output logic             O_IRQ
);
  import ltq_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    // Configuration written by software
    logic       en;
    logic       cls_state;
    ltq_fn_t    fn;
    ltq_when_t  when;
    logic       normal;
    logic       falling;
    logic [7:0] pre;
    logic [31:0] limit;
    logic [6:0] holdoff;
    logic [23:0] tbase;
    logic [1:0] status;
    logic [1:0] mask;
    // Sequencing
    ltq_state_t fsm;
    logic [31:0] cnt;
    logic [31:0] auto_cnt;
    logic       prev_fn;
    logic       prev_clk;
    // Registered outputs
    logic [31:0] rdata;
    logic       trig;
    logic       acq;
    logic       armed;
    logic       irq;
  } ltq_regs_t;

  ltq_regs_t r_reg;
  ltq_regs_t r_next;

  logic [3:0]  in_sync;
  logic        fn_pat;
  logic        fn_st;
  logic [7:0]  pre_st;
  logic [31:0] hold_cycles;
  logic [31:0] timeout_cycles;
  logic        clk_edge;
  logic        want_true;
  logic        fire;
  logic        auto_go;
  logic [1:0]  events;
  logic [1:0]  clr;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  ltq_sync #(
    .WIDTH (4)
  ) u_sync (
    .i_clk   (I_CLK_SYS),
    .i_rstn  (I_RSTN),
    .i_async ({I_INPUT_FOUR_CLOCK, I_INPUT_THREE, I_INPUT_TWO, I_INPUT_ONE}),
    .o_sync  (in_sync)
  );

  // ----------------------------------------
  // Combining functions
  // ----------------------------------------
  // Pattern class sees all four inputs
  ltq_logic_fn #(
    .N (4)
  ) u_fn_pat (
    .i_data   (in_sync),
    .i_pre    (r_reg.pre),
    .i_fn     (r_reg.fn),
    .o_result (fn_pat)
  ); // RL4 RL5 RL6

  // State class: input four is the clock, forced to ignore
  assign pre_st = {LTQ_PRE_X, r_reg.pre[5:0]};

  ltq_logic_fn #(
    .N (4)
  ) u_fn_st (
    .i_data   (in_sync),
    .i_pre    (pre_st),
    .i_fn     (r_reg.fn),
    .o_result (fn_st)
  ); // RL13 RL14

  // ----------------------------------------
  // Derived periods
  // ----------------------------------------
  // Holdoff unit is one timebase step per percent
  // Both products fit in 32 bits for every holdoff and timebase setting
  assign hold_cycles    = 32'(r_reg.holdoff) * 32'(r_reg.tbase); // RL3
  assign timeout_cycles = 32'(r_reg.tbase) * LTQ_AUTO_UNITS; // RL1

  // Edge taken on the synchronised copy, so state decisions lag the pin
  assign clk_edge  = r_reg.falling ? (r_reg.prev_clk && !in_sync[3])
                                   : (!r_reg.prev_clk && in_sync[3]); // RL11 RL13
  assign want_true = (r_reg.when != LTQ_WHEN_FALSE);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    r_next       = r_reg;
    r_next.trig  = 1'b0;
    r_next.acq   = 1'b0;
    r_next.rdata = 32'h0000_0000;
    fire         = 1'b0;
    auto_go      = 1'b0;
    events       = 2'h0;
    clr          = 2'h0;
    r_next.prev_clk = in_sync[3];

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    if (I_WR) begin
      case (I_ADDR)
        LTQ_OFF_CTRL: begin
          r_next.en        = I_WDATA[LTQ_CTRL_EN];
          r_next.cls_state = I_WDATA[LTQ_CTRL_CLASS];
          r_next.fn        = ltq_fn_t'(I_WDATA[LTQ_CTRL_FN_LO +: 2]);
          r_next.when      = ltq_when_t'(I_WDATA[LTQ_CTRL_WHEN_LO +: 2]);
          r_next.normal    = I_WDATA[LTQ_CTRL_NORMAL];
          r_next.falling   = I_WDATA[LTQ_CTRL_FALLING];
        end
        LTQ_OFF_PRECOND: r_next.pre     = I_WDATA[7:0]; // RL5
        LTQ_OFF_LIMIT:   r_next.limit   = I_WDATA;
        LTQ_OFF_HOLDOFF: r_next.holdoff = I_WDATA[6:0]; // RL3
        LTQ_OFF_TBASE:   r_next.tbase   = I_WDATA[23:0];
        LTQ_OFF_STATUS:  clr            = I_WDATA[1:0];
        LTQ_OFF_MASK:    r_next.mask    = I_WDATA[1:0];
        // State offset is read-only and falls to default
        default: ;
      endcase
    end

    // ----------------------------------------
    // Register reads, data in the following cycle
    // ----------------------------------------
    if (I_RD) begin
      case (I_ADDR)
        LTQ_OFF_CTRL: r_next.rdata = {24'h00_0000, r_reg.falling, r_reg.normal,
                                      r_reg.when, r_reg.fn, r_reg.cls_state, r_reg.en};
        LTQ_OFF_PRECOND: r_next.rdata = {24'h00_0000, r_reg.pre};
        LTQ_OFF_LIMIT:   r_next.rdata = r_reg.limit;
        LTQ_OFF_HOLDOFF: r_next.rdata = {25'h000_0000, r_reg.holdoff};
        LTQ_OFF_TBASE:   r_next.rdata = {8'h00, r_reg.tbase};
        LTQ_OFF_STATUS:  r_next.rdata = {30'h0000_0000, r_reg.status};
        LTQ_OFF_MASK:    r_next.rdata = {30'h0000_0000, r_reg.mask};
        LTQ_OFF_STATE:   r_next.rdata = {24'h00_0000, in_sync, fn_st, fn_pat, r_reg.fsm};
        default:         r_next.rdata = 32'h0000_0000;
      endcase
    end

    // ----------------------------------------
    // Trigger sequencing
    // ----------------------------------------
    case (r_reg.fsm)
      LTQ_S_IDLE: begin
        // Leaving idle always passes through holdoff first
        if (r_reg.en) begin
          r_next.fsm = LTQ_S_HOLD;
          r_next.cnt = hold_cycles;
        end
      end
      LTQ_S_HOLD: begin
        // Nothing is evaluated until holdoff runs out
        if (r_reg.cnt == 32'h0000_0000) begin // RL3
          r_next.fsm      = LTQ_S_ARMED;
          r_next.auto_cnt = timeout_cycles;
          r_next.prev_fn  = fn_pat; // RL16
        end else begin
          r_next.cnt = r_reg.cnt - 32'h0000_0001;
        end
      end
      LTQ_S_ARMED: begin
        r_next.prev_fn = fn_pat;
        if (r_reg.cls_state) begin
          // Inputs one-three sampled only at the qualifying edge
          if (clk_edge && (fn_st == want_true)) begin // RL11 RL12 RL17
            fire = 1'b1;
          end
        end else if (r_reg.when == LTQ_WHEN_TRUE) begin
          fire = fn_pat && !r_reg.prev_fn; // RL15
        end else if (r_reg.when == LTQ_WHEN_FALSE) begin
          fire = !fn_pat && r_reg.prev_fn; // RL15
        end else if (fn_pat && !r_reg.prev_fn) begin
          // Timed qualifiers count from the first true cycle
          r_next.fsm = LTQ_S_TIMING; // RL9
          r_next.cnt = 32'h0000_0001;
        end
      end
      LTQ_S_TIMING: begin
        r_next.prev_fn = fn_pat;
        // Count saturates so a very long true time still reads as longer
        if (fn_pat) begin
          if (r_reg.cnt != LTQ_CNT_MAX) begin
            r_next.cnt = r_reg.cnt + 32'h0000_0001; // RL9
          end
        end else begin
          // Decision made only once the function falls, never at the limit
          if (r_reg.when == LTQ_WHEN_LESS) begin
            fire = (r_reg.cnt < r_reg.limit); // RL7 RL10
          end else begin
            fire = (r_reg.cnt > r_reg.limit); // RL8 RL10
          end
          r_next.fsm = LTQ_S_ARMED;
        end
      end
      default: r_next.fsm = LTQ_S_IDLE;
    endcase

    // ----------------------------------------
    // Auto timeout runs while waiting for a decision
    // ----------------------------------------
    if ((r_reg.fsm == LTQ_S_ARMED) || (r_reg.fsm == LTQ_S_TIMING)) begin
      if (r_reg.auto_cnt != 32'h0000_0000) begin
        r_next.auto_cnt = r_reg.auto_cnt - 32'h0000_0001;
      end else if (!r_reg.normal && !fire) begin
        auto_go = 1'b1; // RL1 RL2
      end
    end

    // ----------------------------------------
    // Acquisition start
    // ----------------------------------------
    // Either source restarts holdoff, so starts never overlap
    if (fire || auto_go) begin
      r_next.acq = 1'b1; // RL2
      r_next.trig = fire;
      r_next.fsm = LTQ_S_HOLD;
      r_next.cnt = hold_cycles;
    end
    events = {auto_go, fire};

    // Disable wins over sequencing; a pulse decided now still goes out
    if (!r_next.en) begin
      r_next.fsm = LTQ_S_IDLE;
    end
    r_next.armed = (r_next.fsm == LTQ_S_ARMED) || (r_next.fsm == LTQ_S_TIMING);

    // ----------------------------------------
    // Status and interrupt
    // ----------------------------------------
    // New event wins over a simultaneous clear
    r_next.status = (r_reg.status & ~clr) | events;
    r_next.irq    = |(r_next.status & r_next.mask);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      r_reg          <= '0;
      // Fields reset from named constants; only limit and timebase are not zero
      r_reg.pre      <= LTQ_RST_PRECOND;
      r_reg.limit    <= LTQ_RST_LIMIT;
      r_reg.holdoff  <= LTQ_RST_HOLDOFF;
      r_reg.tbase    <= LTQ_RST_TBASE;
      r_reg.fsm      <= LTQ_S_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // Outputs, straight from the state register
  // ----------------------------------------
  assign O_RDATA     = r_reg.rdata;
  assign O_TRIGGER   = r_reg.trig;
  assign O_ACQ_START = r_reg.acq;
  assign O_ARMED     = r_reg.armed;
  assign O_IRQ       = r_reg.irq;

endmodule

`default_nettype wire

// file: rtl/ltq_pkg.sv
// Constants, register map and types of the logic trigger qualifier.
// Assumes one system clock and software on a plain strobe register port.
//
// Contract
// RL1: Auto mode starts an acquisition after a timebase-derived timeout without trigger.
// RL2: Normal mode starts an acquisition only on a valid trigger decision.
// RL3: Holdoff is a percentage; evaluation is suppressed until its period ends.
// RL4: Pattern class combines all four inputs, no clock input involved.
// RL5: Each pattern input holds an independent high, low or ignore precondition.
// RL6: Pattern class applies one selectable AND, OR, NAND or NOR function.
// RL7: Shorter-than qualifier triggers only if true time was below the limit.
// RL8: Longer-than qualifier triggers only if true time was above the limit.
// RL9: Timed pattern waits for true, times it, stops when it goes false.
// RL10: Timed trigger is placed where the function went false, not at the limit.
// RL11: State class waits for the selected input-four edge, then evaluates inputs one-three.
// RL12: State class triggers only when the sampled result matches the selected polarity.
// RL13: State inputs one-three take high, low or ignore; clock edge rising or falling.
// RL14: State class applies one selectable AND, OR, NAND or NOR to three inputs.
// RL15: Untimed pattern fires when the function goes true, or false if selected.
// RL16: Pattern class samples all inputs when holdoff ends, then evaluates.
// RL17: State class samples non-clock inputs at the qualifying edge, then decides.
// RL18: AND all hold, NAND not all, OR any, NOR none; ignored inputs excluded.

package ltq_pkg;

  // ----------------------------------------
  // Register map, byte addresses
  // ----------------------------------------
  localparam logic [7:0] LTQ_OFF_CTRL    = 8'h00;
  localparam logic [7:0] LTQ_OFF_PRECOND = 8'h04;
  localparam logic [7:0] LTQ_OFF_LIMIT   = 8'h08;
  localparam logic [7:0] LTQ_OFF_HOLDOFF = 8'h0c;
  localparam logic [7:0] LTQ_OFF_TBASE   = 8'h10;
  localparam logic [7:0] LTQ_OFF_STATUS  = 8'h14;
  localparam logic [7:0] LTQ_OFF_MASK    = 8'h18;
  localparam logic [7:0] LTQ_OFF_STATE   = 8'h1c;

  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int LTQ_CTRL_EN      = 0;
  localparam int LTQ_CTRL_CLASS   = 1;
  localparam int LTQ_CTRL_FN_LO   = 2;
  localparam int LTQ_CTRL_WHEN_LO = 4;
  localparam int LTQ_CTRL_NORMAL  = 6;
  localparam int LTQ_CTRL_FALLING = 7;

  // Status bits
  localparam int LTQ_ST_TRIG = 0;
  localparam int LTQ_ST_AUTO = 1;

  // ----------------------------------------
  // Reset values and derived counts
  // ----------------------------------------
  localparam logic [7:0]  LTQ_RST_PRECOND = 8'h00;
  localparam logic [31:0] LTQ_RST_LIMIT   = 32'h0000_0064;
  localparam logic [6:0]  LTQ_RST_HOLDOFF = 7'h00;
  localparam logic [23:0] LTQ_RST_TBASE   = 24'h00_0064;
  // Auto timeout spans this many timebase units (one record)
  localparam logic [31:0] LTQ_AUTO_UNITS  = 32'h0000_000a;
  localparam logic [31:0] LTQ_CNT_MAX     = 32'hffff_ffff;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    LTQ_PRE_X = 2'h0, LTQ_PRE_H = 2'h1, LTQ_PRE_L = 2'h2, LTQ_PRE_R = 2'h3
  } ltq_pre_t;

  typedef enum logic [1:0] {
    LTQ_FN_AND = 2'h0, LTQ_FN_OR = 2'h1, LTQ_FN_NAND = 2'h2, LTQ_FN_NOR = 2'h3
  } ltq_fn_t;

  typedef enum logic [1:0] {
    LTQ_WHEN_TRUE = 2'h0, LTQ_WHEN_FALSE = 2'h1, LTQ_WHEN_LESS = 2'h2, LTQ_WHEN_MORE = 2'h3
  } ltq_when_t;

  // Gray along idle, holdoff, armed, timing
  typedef enum logic [1:0] {
    LTQ_S_IDLE = 2'h0, LTQ_S_HOLD = 2'h1, LTQ_S_ARMED = 2'h3, LTQ_S_TIMING = 2'h2
  } ltq_state_t;

endpackage

// file: rtl/ltq_sync.sv
// Two-stage synchroniser, one per input bit.
// Assumes inputs come from outside the system clock domain.
`timescale 1ns/1ps
`default_nettype none

module ltq_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic [WIDTH-1:0] i_async,
  output var  logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg;

  // ----------------------------------------
  // Per-bit double flop
  // ----------------------------------------
  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        meta_reg[g] <= 1'b0;
        o_sync[g]   <= 1'b0;
      end else begin
        meta_reg[g] <= i_async[g];
        o_sync[g]   <= meta_reg[g];
      end
    end
  end

endmodule

`default_nettype wire

// file: rtl/ltq_logic_fn.sv
// Precondition check and combining function over the logic inputs.
// Assumes synchronised inputs; purely combinational.
`timescale 1ns/1ps
`default_nettype none

module ltq_logic_fn #(
  parameter int N = 4
) (
  input  wire logic [N-1:0]     i_data,
  input  wire logic [2*N-1:0]   i_pre,
  input  wire ltq_pkg::ltq_fn_t i_fn,
  output logic                  o_result
);
  import ltq_pkg::*;

  logic [N-1:0] hit;
  logic [N-1:0] care;
  logic         all_hold;
  logic         any_hold;

  // ----------------------------------------
  // Per-input precondition
  // ----------------------------------------
  for (genvar g = 0; g < N; g++) begin : g_in
    always_comb begin
      care[g] = (i_pre[2*g +: 2] == LTQ_PRE_H) || (i_pre[2*g +: 2] == LTQ_PRE_L);
      hit[g]  = ((i_pre[2*g +: 2] == LTQ_PRE_H) &&  i_data[g]) ||
                ((i_pre[2*g +: 2] == LTQ_PRE_L) && !i_data[g]);
    end
  end

  // Ignored inputs count as holding for AND, absent for OR
  assign all_hold = &(hit | ~care); // RL18
  assign any_hold = |hit; // RL18

  always_comb begin
    case (i_fn)
      LTQ_FN_AND:  o_result = all_hold;
      LTQ_FN_OR:   o_result = any_hold;
      LTQ_FN_NAND: o_result = !all_hold;
      LTQ_FN_NOR:  o_result = !any_hold;
      default:     o_result = all_hold;
    endcase
  end

endmodule

`default_nettype wire

// file: sim/ltq_trigger_chk.sv
// Port checker for the trigger qualifier top.
// Assumes a bind onto ltq_trigger; one clock, reset active low.
`timescale 1ns/1ps
`default_nettype none
module ltq_trigger_chk (
  input wire logic        I_CLK_SYS,
  input wire logic        I_RSTN,
  input wire logic        I_INPUT_ONE,
  input wire logic        I_INPUT_TWO,
  input wire logic        I_INPUT_THREE,
  input wire logic        I_INPUT_FOUR_CLOCK,
  input wire logic [7:0]  I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic        I_WR,
  input wire logic        I_RD,
  input wire logic [31:0] O_RDATA,
  input wire logic        O_TRIGGER,
  input wire logic        O_ACQ_START,
  input wire logic        O_ARMED,
  input wire logic        O_IRQ
);
  import ltq_pkg::*;
  logic       normal_reg;
  logic       class_reg;
  logic [5:0] four_reg;
  logic       four_edge;
  // ----
  // Mode shadow
  // ----
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      normal_reg <= 1'b0;
      class_reg  <= 1'b0;
      four_reg   <= 6'h00;
    end else begin
      four_reg <= {four_reg[4:0], I_INPUT_FOUR_CLOCK};
      if (I_WR && I_ADDR == LTQ_OFF_CTRL) begin
        normal_reg <= I_WDATA[LTQ_CTRL_NORMAL];
        class_reg  <= I_WDATA[LTQ_CTRL_CLASS];
      end
    end
  end
  // Window covers sync depth plus decision register
  assign four_edge = (four_reg[5:1] != four_reg[4:0]);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RSTN);
  sequence s_mask_off;
    I_WR && I_ADDR == LTQ_OFF_MASK && I_WDATA == 32'h0 ##1 !I_WR;
  endsequence
  sequence s_disable;
    I_WR && I_ADDR == LTQ_OFF_CTRL && !I_WDATA[LTQ_CTRL_EN] ##1 !I_WR;
  endsequence
  a_trig_starts_acq: assert property (O_TRIGGER |-> O_ACQ_START)
    else $error("trigger without acquisition start");
  a_normal_no_auto: assert property (normal_reg && O_ACQ_START |-> O_TRIGGER)
    else $error("normal mode started without trigger");
  a_acq_then_hold: assert property (O_ACQ_START |=> !O_ARMED && !O_TRIGGER)
    else $error("no holdoff after acquisition start");
  a_trig_when_armed: assert property (O_TRIGGER |-> $past(O_ARMED))
    else $error("trigger while not evaluating");
  a_state_needs_edge: assert property (class_reg && O_TRIGGER |-> four_edge)
    else $error("state trigger without clock edge");
  a_rdata_idle: assert property (!I_RD || I_ADDR > LTQ_OFF_STATE |=> O_RDATA == 32'h0)
    else $error("read data outside read slot");
  a_irq_masked: assert property (s_mask_off |=> !O_IRQ)
    else $error("interrupt with mask clear");
  a_disable_idle: assert property (s_disable |=> ##1 !O_ARMED && !O_TRIGGER)
    else $error("activity after disable");
endmodule
`default_nettype wire

// file: sim/ltq_probe_model.sv
// Thresholded probe channels feeding the qualifier.
// Assumes level requests from the bench; slow adds a cycle of lag.
`timescale 1ns/1ps
`default_nettype none
module ltq_probe_model (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic [3:0] i_level,
  input  wire logic       i_slow,
  output var  logic       o_input_one,
  output var  logic       o_input_two,
  output var  logic       o_input_three,
  output var  logic       o_input_four_clock
);
  logic [3:0] stage_reg;
  logic [3:0] line_reg;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stage_reg <= 4'h0;
      line_reg  <= 4'h0;
    end else begin
      stage_reg <= i_level;
      line_reg  <= i_slow ? stage_reg : i_level;
    end
  end
  assign {o_input_four_clock, o_input_three, o_input_two, o_input_one} = line_reg;
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the trigger qualifier.
// Assumes the probe model drives all four inputs.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ltq_pkg::*;
  logic I_CLK_SYS, I_RSTN, I_WR, I_RD;
  logic I_INPUT_ONE, I_INPUT_TWO, I_INPUT_THREE, I_INPUT_FOUR_CLOCK;
  logic [7:0] I_ADDR, p;
  logic [31:0] I_WDATA, O_RDATA, rv;
  logic O_TRIGGER, O_ACQ_START, O_ARMED, O_IRQ, slow, fl;
  logic [3:0] lvl, a, b;
  logic [1:0] f, w;
  integer seed, n, t0, i, d;
  int error_cnt = 0;
  int samples_checked = 0;
  int trig_cnt = 0;
  int acq_cnt = 0;
  ltq_probe_model probe_u (.i_clk(I_CLK_SYS), .i_rstn(I_RSTN), .i_level(lvl),
    .i_slow(slow), .o_input_one(I_INPUT_ONE), .o_input_two(I_INPUT_TWO),
    .o_input_three(I_INPUT_THREE), .o_input_four_clock(I_INPUT_FOUR_CLOCK));
  ltq_trigger dut_u (.I_CLK_SYS(I_CLK_SYS), .I_RSTN(I_RSTN), .I_INPUT_ONE(I_INPUT_ONE),
    .I_INPUT_TWO(I_INPUT_TWO), .I_INPUT_THREE(I_INPUT_THREE),
    .I_INPUT_FOUR_CLOCK(I_INPUT_FOUR_CLOCK), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_TRIGGER(O_TRIGGER),
    .O_ACQ_START(O_ACQ_START), .O_ARMED(O_ARMED), .O_IRQ(O_IRQ));
  initial begin
    I_CLK_SYS = 1'b0;
    forever #4 I_CLK_SYS = ~I_CLK_SYS;
  end
  // Mid-cycle count keeps pulse sampling off the launch edge
  always @(negedge I_CLK_SYS) begin
    if (O_TRIGGER === 1'b1) trig_cnt++;
    if (O_ACQ_START === 1'b1) acq_cnt++;
  end
  // ----
  // Helpers
  // ----
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge I_CLK_SYS);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge I_CLK_SYS);
    I_WR <= 1'b1;
    I_ADDR <= ad;
    I_WDATA <= v;
    @(posedge I_CLK_SYS);
    I_WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] v);
    @(posedge I_CLK_SYS);
    I_RD <= 1'b1;
    I_ADDR <= ad;
    @(posedge I_CLK_SYS);
    I_RD <= 1'b0;
    #1 v = O_RDATA;
  endtask
  function automatic logic fnval(input logic [7:0] pp, input logic [3:0] dd,
                                 input logic [1:0] ff, input int k);
    logic al;
    logic an;
    logic h;
    al = 1'b1;
    an = 1'b0;
    for (int j = 0; j < k; j++) begin
      h = (pp[2*j+:2] == 2'h1) ? dd[j] : !dd[j];
      if (pp[2*j+:2] == 2'h1 || pp[2*j+:2] == 2'h2) begin
        al &= h;
        an |= h;
      end
    end
    return ff == 2'h0 ? al : ff == 2'h1 ? an : ff == 2'h2 ? !al : !an;
  endfunction
  function automatic logic [31:0] ctrl(input logic c, input logic [1:0] ff,
                                       input logic [1:0] ww, input logic nm, input logic fe);
    return {24'h0, fe, nm, ww, ff, c, 1'b1};
  endfunction
  task automatic setup(input logic [7:0] pp, input logic [31:0] cv, input logic [3:0] lv);
    wr(LTQ_OFF_CTRL, 32'h0);
    lvl <= lv;
    wr(LTQ_OFF_PRECOND, {24'h0, pp});
    wr(LTQ_OFF_CTRL, cv);
    n = 0;
    while (O_ARMED !== 1'b1 && n < 300) begin
      @(negedge I_CLK_SYS);
      n++;
    end
    chk("armed", 32'h1, 32'(n < 300));
  endtask
  task automatic pat(input logic [7:0] pp, input logic [3:0] av, input logic [3:0] bv);
    setup(pp, ctrl(1'b0, f, w, 1'b1, 1'b0), av);
    tick(4);
    t0 = trig_cnt;
    lvl <= bv;
    tick(8);
    chk("pattern", 32'(w[0] ? fnval(pp, av, f, 4) && !fnval(pp, bv, f, 4)
                            : !fnval(pp, av, f, 4) && fnval(pp, bv, f, 4)), trig_cnt - t0);
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    #400000;
    error_cnt++;
    results();
  end
  initial begin
    logic [7:0]  ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20, 8'h1c};
    logic [31:0] rw [9] = '{32'h0, 32'h0, 32'h64, 32'h0, 32'h64, 32'h0, 32'h0, 32'h0, 32'hc};
    int durs [5] = '{3, 4, 5, 6, 12};
    seed = 32'h1c93;
    {I_RSTN, I_WR, I_RD, I_ADDR, I_WDATA, lvl, slow, f, w} = '0;
    tick(4);
    chk("reset outputs", 32'h0, {O_TRIGGER, O_ACQ_START, O_ARMED, O_IRQ});
    I_RSTN <= 1'b1;
    wr(8'h20, 32'hffff_ffff);
    for (i = 0; i < 9; i++) begin
      rd(ra[i], rv);
      chk("reset value", rw[i], rv);
    end
    $display("test registers done");
    wr(LTQ_OFF_TBASE, 32'h2);
    wr(LTQ_OFF_HOLDOFF, 32'h1);
    wr(LTQ_OFF_MASK, 32'h1);
    for (i = 0; i < 48; i++) begin
      f = 2'(i % 4);
      w = 2'((i / 4) % 2);
      slow <= 1'($random(seed));
      pat(i < 8 ? 8'h00 : 8'($random(seed)), 4'($random(seed)), 4'($random(seed)));
    end
    $display("test pattern done");
    {f, w} = 4'h0;
    wr(LTQ_OFF_STATUS, 32'h3);
    tick(1);
    chk("irq idle", 32'h0, 32'(O_IRQ));
    pat(8'h01, 4'h0, 4'h1);
    chk("irq set", 32'h1, 32'(O_IRQ));
    wr(LTQ_OFF_STATUS, 32'h1);
    tick(2);
    chk("irq clear", 32'h0, 32'(O_IRQ));
    wr(LTQ_OFF_MASK, 32'h0);
    pat(8'h01, 4'h0, 4'h1);
    rd(LTQ_OFF_STATUS, rv);
    chk("status trig", 32'h1, rv & 32'h1);
    $display("test interrupt done");
    wr(LTQ_OFF_LIMIT, 32'h5);
    for (i = 0; i < 10; i++) begin
      d = durs[i % 5];
      w = 2'(2 + i / 5);
      setup(8'h01, ctrl(1'b0, 2'h0, w, 1'b1, 1'b0), 4'h0);
      tick(4);
      lvl <= 4'h1;
      t0 = trig_cnt;
      tick(d);
      lvl <= 4'h0;
      chk("early trigger", t0, trig_cnt);
      tick(8);
      chk("timed", 32'(w == 2'h2 ? d < 5 : d > 5), trig_cnt - t0);
    end
    $display("test timed done");
    wr(LTQ_OFF_HOLDOFF, 32'h5);
    setup(8'h00, ctrl(1'b0, 2'h0, 2'h0, 1'b0, 1'b0), 4'h0);
    t0 = acq_cnt;
    d = trig_cnt;
    n = 0;
    while (acq_cnt == t0 && n < 100) begin
      @(posedge I_CLK_SYS);
      n++;
    end
    chk("auto delay", 32'h1, 32'(n >= 18 && n <= 22));
    n = 0;
    while (O_ARMED !== 1'b1 && n < 100) begin
      @(negedge I_CLK_SYS);
      n++;
    end
    chk("holdoff span", 32'h1, 32'(n >= 10 && n <= 12));
    rd(LTQ_OFF_STATUS, rv);
    chk("status auto", 32'h2, rv & 32'h2);
    chk("auto trigger", 32'h0, 32'(trig_cnt - d));
    setup(8'h00, ctrl(1'b0, 2'h0, 2'h0, 1'b1, 1'b0), 4'h0);
    t0 = acq_cnt;
    tick(60);
    chk("normal idle", t0, acq_cnt);
    $display("test modes done");
    wr(LTQ_OFF_HOLDOFF, 32'h1);
    for (i = 0; i < 32; i++) begin
      p = 8'($random(seed));
      a = 4'($random(seed));
      f = 2'(i % 4);
      w = 2'((i / 4) % 2);
      fl = 1'((i / 8) % 2);
      setup(p, ctrl(1'b1, f, w, 1'b1, fl), {fl, a[2:0]});
      tick(4);
      t0 = trig_cnt;
      lvl[3] <= !fl;
      tick(8);
      chk("state", 32'(fnval(p, a, f, 3) == !w[0]), trig_cnt - t0);
      t0 = trig_cnt;
      lvl[3] <= fl;
      tick(8);
      chk("wrong edge", t0, trig_cnt);
    end
    $display("test state done");
    results();
  end
endmodule
bind ltq_trigger ltq_trigger_chk chk_u (.I_CLK_SYS(I_CLK_SYS), .I_RSTN(I_RSTN),
  .I_INPUT_ONE(I_INPUT_ONE), .I_INPUT_TWO(I_INPUT_TWO), .I_INPUT_THREE(I_INPUT_THREE),
  .I_INPUT_FOUR_CLOCK(I_INPUT_FOUR_CLOCK), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_TRIGGER(O_TRIGGER),
  .O_ACQ_START(O_ACQ_START), .O_ARMED(O_ARMED), .O_IRQ(O_IRQ));
`default_nettype wire
